// ==== common/csr_pkg.sv ====
// core special-function register bank: addresses, masks, reset values
// assumes a 12-bit data address space with the core registers at the top
package csr_pkg;

  // ----------------------------------------------------------------
  // address space
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;                       // data memory address width
  localparam int DATA_W = 8;                        // register width
  localparam int IDX_W = 6;                         // index into the core bank
  localparam int NUM_REGS = 40;                     // core locations held here
  localparam logic [11:0] SFR_BASE = 12'hFD8;       // lowest core location

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] A_STACK_TOP_UPPER = 12'hFFF;
  localparam logic [11:0] A_STACK_TOP_HIGH = 12'hFFE;
  localparam logic [11:0] A_STACK_TOP_LOW = 12'hFFD;
  localparam logic [11:0] A_RETURN_STACK_POINTER = 12'hFFC;
  localparam logic [11:0] A_PROGRAM_COUNTER_UPPER_LATCH = 12'hFFB;
  localparam logic [11:0] A_PROGRAM_COUNTER_HIGH_LATCH = 12'hFFA;
  localparam logic [11:0] A_PROGRAM_COUNTER_LOW = 12'hFF9;
  localparam logic [11:0] A_TABLE_POINTER_UPPER = 12'hFF8;
  localparam logic [11:0] A_MULTIPLY_PRODUCT_HIGH = 12'hFF4;
  localparam logic [11:0] A_INTERRUPT_CONTROL_MAIN = 12'hFF2;
  localparam logic [11:0] A_INTERRUPT_CONTROL_EDGES_PRIORITY = 12'hFF1;
  localparam logic [11:0] A_INTERRUPT_CONTROL_EXTERNAL = 12'hFF0;
  localparam logic [11:0] A_INDIRECT0_POINTER_HIGH = 12'hFEA;
  localparam logic [11:0] A_INDIRECT0_POINTER_LOW = 12'hFE9;
  localparam logic [11:0] A_WORKING_REGISTER = 12'hFE8;
  localparam logic [11:0] A_INDIRECT1_POINTER_HIGH = 12'hFE2;
  localparam logic [11:0] A_INDIRECT1_POINTER_LOW = 12'hFE1;
  localparam logic [11:0] A_BANK_SELECT = 12'hFE0;
  localparam logic [11:0] A_INDIRECT2_POINTER_HIGH = 12'hFDA;
  localparam logic [11:0] A_INDIRECT2_POINTER_LOW = 12'hFD9;
  localparam logic [11:0] A_ARITHMETIC_FLAGS = 12'hFD8;

  // ----------------------------------------------------------------
  // indirect port layout: ports sit at pointer_low + 2 .. + 6
  // ----------------------------------------------------------------
  localparam logic [11:0] PORT_GAP = 12'h002;       // pointer low to first port
  localparam logic [2:0] K_PLUS_WORKING = 3'h0;
  localparam logic [2:0] K_PRE_INCREMENT = 3'h1;
  localparam logic [2:0] K_POST_DECREMENT = 3'h2;
  localparam logic [2:0] K_POST_INCREMENT = 3'h3;
  localparam logic [2:0] K_PLAIN = 3'h4;
  localparam logic [11:0] PTR_ONE = 12'h001;

  // ----------------------------------------------------------------
  // implemented bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] M_FULL = 8'hFF;
  localparam logic [7:0] M_STACK_TOP_UPPER = 8'h1F;
  localparam logic [7:0] M_RETURN_STACK_POINTER = 8'hDF;
  localparam logic [7:0] M_PC_UPPER_LATCH = 8'h1F;  // bit 21 only in test mode
  localparam logic [7:0] M_PC_BIT21 = 8'h20;
  localparam logic [7:0] M_TABLE_POINTER_UPPER = 8'h3F;
  localparam logic [7:0] M_NIBBLE = 8'h0F;          // pointer high, bank select
  localparam logic [7:0] M_ARITHMETIC_FLAGS = 8'h1F;

  // ----------------------------------------------------------------
  // reset values (undefined ones are cleared)
  // ----------------------------------------------------------------
  localparam logic [7:0] R_ZERO = 8'h00;
  localparam logic [7:0] R_INTERRUPT_CONTROL_EDGES_PRIORITY = 8'hFF;
  localparam logic [7:0] R_INTERRUPT_CONTROL_EXTERNAL = 8'hC0;

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  localparam int PC_W = 22;
  localparam int PC_BIT21 = 21;
  localparam logic [21:0] PC_STEP = 22'h000002;     // one instruction word
  localparam logic [21:0] PC_RESET = 22'h000000;

endpackage

// ==== src/csr_core_bank.sv ====
// core special-function register bank with three indirect pointer groups
// assumes the core issues one strobe per cycle and that the data memory
// answers a read combinationally in the same cycle as its address
//
// Behaviour
// - locations below the core bank read as zero
// - indirect ports store nothing, redirect to memory
// - plain port addresses memory at the pointer
// - pre-increment bumps pointer, then uses it
// - upper latch feeds pc bits 20:16 on low write
// - pc low byte reads and writes pc 7:0
// - large-package-only locations read zero on small package
// - pc bit 21 exists only in test mode
//
// limitations:
// - the stack registers are plain storage here; push and pop live in the core
// - pointer arithmetic wraps inside the 12-bit data space
// - a port access that names another port still lands in data memory only
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps

module csr_core_bank #(
  parameter bit LARGE_PACKAGE = 1'b1,             // 1: larger pin-count variant
  parameter logic [39:0] LARGE_ONLY_MASK = 40'h00_0000_0000 // per-index flags
) (
  input wire logic core_clk,                      // 10 MHz core clock
  input wire logic rstn,                          // asynchronous reset, low active
  input wire logic clk_en,                        // freezes all state when low
  input wire logic test_mode,                     // test or serial programming mode
  input wire logic [11:0] reg_addr,               // register address
  input wire logic [7:0] reg_wdata,               // write data
  input wire logic reg_wr,                        // write strobe
  input wire logic reg_rd,                        // read strobe
  output logic [7:0] reg_rdata,                   // read data, cycle after strobe
  input wire logic pc_advance,                    // core steps the program counter
  output logic [21:0] program_counter,            // current program counter
  output logic [7:0] working_register,            // working register copy
  output logic [7:0] bank_select,                 // bank select copy
  output logic [11:0] dmem_addr,                  // redirected memory address
  output logic [7:0] dmem_wdata,                  // redirected write data
  output logic dmem_wr,                           // redirected write strobe
  output logic dmem_rd,                           // redirected read strobe
  input wire logic [7:0] dmem_rdata               // memory read data, same cycle
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // pointer high sits one location above pointer low in every group
  localparam logic [11:0] PTR1 = csr_pkg::PTR_ONE;
  // last port of a group, counted from its pointer low
  localparam logic [11:0] PORT_SPAN = 12'h006;
  // group_low answer for an address that is not a port
  localparam logic [11:0] NO_GROUP = 12'h000;

  // implemented bits of a location; test mode opens pc bit 21
  function automatic logic [7:0] bit_mask(input logic [11:0] a, input logic tm);
    case (a)
      csr_pkg::A_STACK_TOP_UPPER: bit_mask = csr_pkg::M_STACK_TOP_UPPER;
      csr_pkg::A_RETURN_STACK_POINTER: bit_mask = csr_pkg::M_RETURN_STACK_POINTER;
      csr_pkg::A_PROGRAM_COUNTER_UPPER_LATCH:
        bit_mask = tm ? (csr_pkg::M_PC_UPPER_LATCH | csr_pkg::M_PC_BIT21)
                      : csr_pkg::M_PC_UPPER_LATCH;
      csr_pkg::A_TABLE_POINTER_UPPER: bit_mask = csr_pkg::M_TABLE_POINTER_UPPER;
      csr_pkg::A_INDIRECT0_POINTER_HIGH: bit_mask = csr_pkg::M_NIBBLE;
      csr_pkg::A_INDIRECT1_POINTER_HIGH: bit_mask = csr_pkg::M_NIBBLE;
      csr_pkg::A_INDIRECT2_POINTER_HIGH: bit_mask = csr_pkg::M_NIBBLE;
      csr_pkg::A_BANK_SELECT: bit_mask = csr_pkg::M_NIBBLE;
      csr_pkg::A_ARITHMETIC_FLAGS: bit_mask = csr_pkg::M_ARITHMETIC_FLAGS;
      default: bit_mask = csr_pkg::M_FULL;
    endcase
  endfunction

  // reset value of a location
  function automatic logic [7:0] reset_value(input logic [11:0] a);
    case (a)
      csr_pkg::A_INTERRUPT_CONTROL_EDGES_PRIORITY:
        reset_value = csr_pkg::R_INTERRUPT_CONTROL_EDGES_PRIORITY;
      csr_pkg::A_INTERRUPT_CONTROL_EXTERNAL:
        reset_value = csr_pkg::R_INTERRUPT_CONTROL_EXTERNAL;
      default: reset_value = csr_pkg::R_ZERO;
    endcase
  endfunction

  // pointer low address of the group owning an indirect port, or zero;
  // each group's five ports sit just above its pointer high byte
  function automatic logic [11:0] group_low(input logic [11:0] a);
    // group zero: five ports above its pointer high, below the pc latches
    if (a > csr_pkg::A_INDIRECT0_POINTER_HIGH && a < csr_pkg::A_PROGRAM_COUNTER_UPPER_LATCH
        && a <= csr_pkg::A_INDIRECT0_POINTER_LOW + PORT_SPAN)
      group_low = csr_pkg::A_INDIRECT0_POINTER_LOW;
    // group one: between its pointer high and the working register
    else if (a > csr_pkg::A_INDIRECT1_POINTER_HIGH && a < csr_pkg::A_WORKING_REGISTER)
      group_low = csr_pkg::A_INDIRECT1_POINTER_LOW;
    // group two: between its pointer high and bank select
    else if (a > csr_pkg::A_INDIRECT2_POINTER_HIGH && a < csr_pkg::A_BANK_SELECT)
      group_low = csr_pkg::A_INDIRECT2_POINTER_LOW;
    // not a port at all
    else
      group_low = NO_GROUP;
  endfunction

  // index of a location inside the bank
  function automatic logic [5:0] index_of(input logic [11:0] a);
    logic [11:0] d;
    d = a - csr_pkg::SFR_BASE;
    index_of = d[5:0];
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] sfr [0:csr_pkg::NUM_REGS-1];        // core register flops
  logic [21:0] pc;                                // program counter

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic in_bank;                                  // address inside the core bank
  logic [5:0] idx;                                // bank index of the address
  logic absent;                                   // location missing on this package
  logic [11:0] grp_lo;                            // owning pointer group, if a port
  logic is_port;                                  // address is an indirect port
  logic [2:0] kind;                               // which port of the group
  logic [11:0] ptr;                               // current pointer value
  logic [11:0] next_ptr;                          // pointer after the access
  logic [11:0] eff_addr;                          // memory address used
  logic [7:0] wsext;                              // working register, signed offset
  logic is_pcl;                                   // address is the pc low byte
  logic [11:0] kdiff;                             // port distance from the group's first port

  assign in_bank = reg_addr >= csr_pkg::SFR_BASE;
  assign idx = index_of(reg_addr);
  assign absent = !LARGE_PACKAGE && LARGE_ONLY_MASK[idx];
  assign grp_lo = group_low(reg_addr);
  assign is_port = in_bank && (grp_lo != NO_GROUP) && !absent;
  assign kdiff = reg_addr - grp_lo - csr_pkg::PORT_GAP;
  assign kind = kdiff[2:0];
  assign is_pcl = reg_addr == csr_pkg::A_PROGRAM_COUNTER_LOW;
  assign wsext = sfr[index_of(csr_pkg::A_WORKING_REGISTER)];

  // pointer arithmetic for the selected group
  always_comb
  begin
    // no group selected: park at zero rather than index past the bank
    ptr = 12'h000;
    if (grp_lo != NO_GROUP)
      ptr = {sfr[index_of(grp_lo + PTR1)][3:0], sfr[index_of(grp_lo)]};
    next_ptr = ptr;
    eff_addr = ptr;
    case (kind)
      csr_pkg::K_PLAIN:
      begin
        eff_addr = ptr;                           // pointer untouched
      end
      csr_pkg::K_POST_INCREMENT:
      begin
        next_ptr = ptr + csr_pkg::PTR_ONE;
      end
      csr_pkg::K_POST_DECREMENT:
      begin
        next_ptr = ptr - csr_pkg::PTR_ONE;
      end
      csr_pkg::K_PRE_INCREMENT:
      begin
        next_ptr = ptr + csr_pkg::PTR_ONE;
        eff_addr = next_ptr;
      end
      csr_pkg::K_PLUS_WORKING:
      begin
        eff_addr = ptr + {{4{wsext[7]}}, wsext};
      end
      default:
      begin
        eff_addr = ptr;
      end
    endcase
  end

  // redirected memory access; the port itself holds no data
  assign dmem_addr = eff_addr;
  assign dmem_wdata = reg_wdata;
  assign dmem_wr = clk_en && reg_wr && is_port;
  assign dmem_rd = clk_en && reg_rd && is_port;

  // ----------------------------------------------------------------
  // register writes and pointer updates
  // ----------------------------------------------------------------

  // one writer for the bank so pointer steps and bus writes never race;
  // a write to a port changes nothing here but the pointer, the byte goes to memory
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < csr_pkg::NUM_REGS; i++)
        sfr[i] <= reset_value(csr_pkg::SFR_BASE + 12'(i));
    end
    else if (clk_en)
    begin
      // port access: the byte itself goes to memory, only the pointer moves
      if ((reg_wr || reg_rd) && is_port)
      begin
        // an access through a port writes back its pointer; plain and offset ports leave it unchanged
        sfr[index_of(grp_lo)] <= next_ptr[7:0];
        sfr[index_of(grp_lo + PTR1)] <= {4'h0, next_ptr[11:8]};
      end
      // plain register write; the pc low byte is held in the counter itself
      else if (reg_wr && in_bank && !is_pcl && !absent)
      begin
        sfr[idx] <= reg_wdata & bit_mask(reg_addr, test_mode);
      end
      else if (reg_rd && is_pcl)
      begin
        // reading the low byte captures the upper bytes into the latches
        sfr[index_of(csr_pkg::A_PROGRAM_COUNTER_HIGH_LATCH)] <= pc[15:8];
        sfr[index_of(csr_pkg::A_PROGRAM_COUNTER_UPPER_LATCH)] <=
          {2'h0, pc[21:16]} & bit_mask(csr_pkg::A_PROGRAM_COUNTER_UPPER_LATCH, test_mode);
      end
    end
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------

  // a low-byte write loads the whole counter from the latches at once,
  // so software can never see a half-updated jump target
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc <= csr_pkg::PC_RESET;
    end
    else if (clk_en)
    begin
      // a jump written by software wins over the core's own step
      if (reg_wr && is_pcl)
      begin
        pc[7:0] <= reg_wdata;
        pc[15:8] <= sfr[index_of(csr_pkg::A_PROGRAM_COUNTER_HIGH_LATCH)];
        pc[20:16] <= sfr[index_of(csr_pkg::A_PROGRAM_COUNTER_UPPER_LATCH)][4:0];
        pc[csr_pkg::PC_BIT21] <= test_mode
          && sfr[index_of(csr_pkg::A_PROGRAM_COUNTER_UPPER_LATCH)][5];
      end
      // normal step; outside test mode bit 21 is forced low and never carries
      else if (pc_advance)
      begin
        pc <= test_mode ? pc + csr_pkg::PC_STEP
                        : {1'b0, pc[20:0] + csr_pkg::PC_STEP[20:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------

  // read data is registered so it stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      // no read, below the bank or missing on this package: zero
      if (!reg_rd || !in_bank || absent)
        reg_rdata <= 8'h00;
      // port read: the memory answers in the same cycle
      else if (is_port)
        reg_rdata <= dmem_rdata;
      // pc low byte comes live from the counter
      else if (is_pcl)
        reg_rdata <= pc[7:0];
      // everything else, with unimplemented bits cleared
      else
        reg_rdata <= sfr[idx] & bit_mask(reg_addr, test_mode);
    end
  end

  // ----------------------------------------------------------------
  // state copies for the core
  // ----------------------------------------------------------------
  assign program_counter = pc;
  assign working_register = sfr[index_of(csr_pkg::A_WORKING_REGISTER)];
  assign bank_select = sfr[index_of(csr_pkg::A_BANK_SELECT)];

endmodule

// ==== dv/csr_dmem_model.sv ====
// data memory model answering the redirected indirect accesses
// assumes the bank expects read data in the same cycle as dmem_rd
`timescale 1ns/10ps
module csr_dmem_model (
  input wire logic core_clk,
  input wire logic [11:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  input wire logic dmem_wr,
  input wire logic dmem_rd,
  output logic [7:0] dmem_rdata
);
  logic [7:0] mem [4096]; // seeded with an address pattern
  logic [7:0] last = 8'h00; // last byte handed out
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end
  // ----------------------------------------
  // writes land at the edge that takes them
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (dmem_wr)
      mem[dmem_addr] <= dmem_wdata;
    if (dmem_rd)
      last <= dmem_rdata;
  end
  // idle bus shows the inverse of the last byte so stale data never matches
  assign dmem_rdata = dmem_rd ? mem[dmem_addr] : ~last;
endmodule

// ==== dv/csr_core_bank_sva.sv ====
// port checker for the core register bank
// assumes one clock domain and the registered read data of the bank
`timescale 1ns/10ps
module csr_core_bank_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic test_mode,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [21:0] program_counter,
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_rd,
  input wire logic [7:0] dmem_rdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // taken accesses
  // ----------------------------------------
  sequence s_rd(logic [11:0] a);
    clk_en && reg_rd && reg_addr == a;
  endsequence
  sequence s_wr(logic [11:0] a);
    clk_en && reg_wr && reg_addr == a;
  endsequence
  property p_unimpl;
    clk_en && reg_rd && reg_addr < 12'hFD8 |=> reg_rdata == 8'h00;
  endproperty
  property p_redirect;
    clk_en && reg_rd && reg_addr inside {[12'hFEB:12'hFEF]}
      |-> dmem_rd ##1 reg_rdata == $past(dmem_rdata);
  endproperty
  property p_no_stray;
    dmem_rd |-> reg_rd && clk_en;
  endproperty
  property p_plain;
    s_rd(12'hFEF) ##1 s_rd(12'hFEF) |-> dmem_addr == $past(dmem_addr);
  endproperty
  property p_postinc;
    s_rd(12'hFEE) ##1 s_rd(12'hFEF) |-> dmem_addr == $past(dmem_addr) + 12'h001;
  endproperty
  property p_postdec;
    s_rd(12'hFED) ##1 s_rd(12'hFEF) |-> dmem_addr == $past(dmem_addr) - 12'h001;
  endproperty
  property p_preinc;
    s_rd(12'hFEF) ##1 s_rd(12'hFEC) |-> dmem_addr == $past(dmem_addr) + 12'h001;
  endproperty
  property p_plusw;
    s_rd(12'hFEF) ##1 s_rd(12'hFEB) ##1 s_rd(12'hFEF) |-> dmem_addr == $past(dmem_addr, 2);
  endproperty
  property p_pc_low;
    s_wr(12'hFF9) |=> program_counter[7:0] == $past(reg_wdata);
  endproperty
  property p_pc_upper;
    s_wr(12'hFFB) ##1 s_wr(12'hFF9) |=> program_counter[20:16] == $past(reg_wdata[4:0], 2);
  endproperty
  property p_bit21;
    s_wr(12'hFF9) ##0 !test_mode |=> !program_counter[21];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unmapped read not zero");
  a_redirect: assert property (p_redirect) else $error("port read not redirected");
  a_no_stray: assert property (p_no_stray) else $error("memory read without request");
  a_plain: assert property (p_plain) else $error("plain port moved pointer");
  a_postinc: assert property (p_postinc) else $error("post increment wrong");
  a_postdec: assert property (p_postdec) else $error("post decrement wrong");
  a_preinc: assert property (p_preinc) else $error("pre increment wrong");
  a_plusw: assert property (p_plusw) else $error("offset port moved pointer");
  a_pc_low: assert property (p_pc_low) else $error("pc low byte not loaded");
  a_pc_upper: assert property (p_pc_upper) else $error("pc upper bits not loaded");
  a_bit21: assert property (p_bit21) else $error("pc bit 21 set outside test");
endmodule
bind csr_core_bank csr_core_bank_sva u_sva (.core_clk(core_clk), .rstn(rstn),
  .clk_en(clk_en), .test_mode(test_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .program_counter(program_counter), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
  .dmem_rdata(dmem_rdata));

// ==== dv/core_sfr_indirect_access_tb_top.sv ====
// self-checking bench for the core register bank on the small package
// assumes bank select (bank index 8) is flagged as large-package only
`timescale 1ns/10ps
module core_sfr_indirect_access_tb_top;
  logic core_clk, rstn, clk_en, test_mode, reg_wr, reg_rd, pc_advance, dmem_wr, dmem_rd;
  logic [11:0] reg_addr, dmem_addr;
  logic [7:0] reg_wdata, reg_rdata, working_register, bank_select, dmem_wdata, dmem_rdata;
  logic [21:0] program_counter;
  int num_errors = 0;
  int cmp_count = 0;
  logic [11:0] pa [10] = '{12'hFEF, 12'hFEF, 12'hFEE, 12'hFEF, 12'hFED,
    12'hFEF, 12'hFEC, 12'hFEF, 12'hFEB, 12'hFEF}; // port walk
  logic [11:0] ma [10] = '{12'h120, 12'h120, 12'h120, 12'h121, 12'h121,
    12'h120, 12'h121, 12'h121, 12'h11F, 12'h121}; // memory reached
  logic [11:0] gl [3] = '{12'hFE9, 12'hFE1, 12'hFD9}; // pointer low per group
  csr_core_bank #(.LARGE_PACKAGE(1'b0), .LARGE_ONLY_MASK(40'h00_0000_0100)) dut (
    .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .test_mode(test_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pc_advance(pc_advance), .program_counter(program_counter),
    .working_register(working_register), .bank_select(bank_select),
    .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_wr(dmem_wr),
    .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata));
  csr_dmem_model u_mem (.core_clk(core_clk), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_wr(dmem_wr), .dmem_rd(dmem_rd),
    .dmem_rdata(dmem_rdata));
  // 100 ns period
  always #50 core_clk = ~core_clk;
  // untouched memory byte, same seed pattern as the model
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [21:0] e, input logic [21:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
  endtask
  // strobe now, data checked mid-cycle after; leaves the bus free back to back
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    fork
      begin
        repeat (2) @(negedge core_clk);
        chk("reg_rdata", e, reg_rdata);
      end
    join_none
  endtask
  task automatic idle();
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    pc_advance <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic summarize();
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog, far beyond the fewer than 100 cycles the tests take
  initial
  begin
    #(100 * 5000);
    num_errors++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0; rstn = 1'b0; clk_en = 1'b1; test_mode = 1'b0; reg_wr = 1'b0;
    reg_rd = 1'b0; pc_advance = 1'b0; reg_addr = 12'h000; reg_wdata = 8'h00;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    for (logic [12:0] a = 13'hFD8; a <= 13'hFFF; a++)
      if (!(a[11:0] inside {[12'hFDB:12'hFDF], [12'hFE3:12'hFE7], [12'hFEB:12'hFEF]}))
        rd(a[11:0], a == 13'hFF1 ? 8'hFF : a == 13'hFF0 ? 8'hC0 : 8'h00);
    wr(12'hFD7, 8'hA5);
    rd(12'hFD7, 8'h00);
    rd(12'h000, 8'h00);
    wr(12'hFEA, 8'h01);
    wr(12'hFE9, 8'h20);
    wr(12'hFE8, 8'hFE);
    for (int i = 0; i < 10; i++)
      rd(pa[i], pat(ma[i]));
    rd(12'hFE9, 8'h21);
    for (int g = 0; g < 3; g++)
    begin
      wr(gl[g] + 12'h001, 8'h02);
      wr(gl[g], 8'h10 + 8'(g));
      wr(gl[g] + 12'h006, 8'hC0 + 8'(g));
      rd(gl[g] + 12'h006, 8'hC0 + 8'(g));
      rd(gl[g] + 12'h005, 8'hC0 + 8'(g));
      rd(gl[g] + 12'h006, pat(12'h211 + 12'(g)));
    end
    wr(12'hFFA, 8'h34);
    wr(12'hFFB, 8'h2A);
    wr(12'hFF9, 8'h56);
    idle();
    chk("program_counter", 22'h0A3456, program_counter);
    @(posedge core_clk);
    test_mode <= 1'b1;
    wr(12'hFFB, 8'h2A);
    wr(12'hFF9, 8'h56);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    pc_advance <= 1'b1;
    idle();
    chk("program_counter", 22'h2A3458, program_counter);
    rd(12'hFF9, 8'h58);
    wr(12'hFE0, 8'h05);
    rd(12'hFE0, 8'h00);
    idle();
    chk("bank_select", 22'h0, bank_select);
    chk("working_register", 22'hFE, working_register);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(12'hFE8, 8'h11);
    idle();
    @(posedge core_clk);
    clk_en <= 1'b1;
    idle();
    chk("working_register", 22'hFE, working_register);
    repeat (3) idle();
    summarize();
  end
endmodule
